// >>> verilog/cwdp_consts.vh
// Constants for the configuration word decode and protection block
`ifndef CWDP_CONSTS_VH
`define CWDP_CONSTS_VH
// Register indices; APB byte address is four times the index
`define CWDP_IDX_UID0 16'h8000
`define CWDP_IDX_UID1 16'h8001
`define CWDP_IDX_UID2 16'h8002
`define CWDP_IDX_UID3 16'h8003
`define CWDP_IDX_PART_REVISION_ID 16'h8006
`define CWDP_IDX_CFG1 16'h8007
`define CWDP_IDX_CFG2 16'h8008
`define CWDP_IDX_CTRL 16'h8009
`define CWDP_IDX_STAT 16'h800a
// Blank (erased) word value
`define CWDP_BLANK 14'h3fff
// Unimplemented bit masks, always read as one
`define CWDP_C1_UNIMP 14'h3104
`define CWDP_C2_UNIMP 14'h01fc
// First configuration word field positions
`define CWDP_C1_CLOCK_OUTPUT_PIN 11
`define CWDP_C1_BOR 9
`define CWDP_C1_CP 7
`define CWDP_C1_EXTERNAL_RESET_PIN 6
`define CWDP_C1_POWERUP_DELAY_TIMER 5
`define CWDP_C1_WDT 3
`define CWDP_C1_FOSC 0
// Second configuration word field positions
`define CWDP_C2_LVP 13
`define CWDP_C2_DBG 12
`define CWDP_C2_LOW_POWER_BROWNOUT_ENABLE_N 11
`define CWDP_C2_BROWNOUT_TRIP_SELECT 10
`define CWDP_C2_STV 9
`define CWDP_C2_WRT 0
// Two-bit enable field codes
`define CWDP_EN_ON 2'h3
`define CWDP_EN_RUN 2'h2
`define CWDP_EN_SW 2'h1
`define CWDP_EN_OFF 2'h0
// Clock source code for the internal oscillator
`define CWDP_FOSC_INT 2'h0
// Self-write protection limits, 4 kW then 8 kW
`define CWDP_LIM4_SMALL 13'h01ff
`define CWDP_LIM4_HALF 13'h07ff
`define CWDP_LIM4_ALL 13'h0fff
`define CWDP_LIM8_SMALL 13'h01ff
`define CWDP_LIM8_HALF 13'h0fff
`define CWDP_LIM8_ALL 13'h1fff
// Control and status bit positions
`define CWDP_CTRL_SBOR 0
`define CWDP_CTRL_SWDT 1
`define CWDP_STAT_OVF 0
`define CWDP_STAT_UNF 1
// Programmer port word selects
`define CWDP_PSEL_PART_REVISION_ID 4'h6
`define CWDP_PSEL_CFG1 4'h7
`define CWDP_PSEL_CFG2 4'h8
`endif

// >>> verilog/cwdp_top.v
// Configuration word decode, code and write protection, ID storage
//
// Functional notes
// - Clock-out bit low routes clock to pin
// - Brown-out field: on, run-only, software, off
// - Code protect bit active low
// - Reset-pin select ignored under low-voltage programming
// - Power-up timer enable active low
// - Watchdog field: on, run-only, software, off
// - Clock source field selects external or internal
// - Brown-out never enables power-up timer itself
// - Code protection cleared only by bulk erase or by reset
// - Unimplemented and blank bits read one
// - Low-voltage programming bit, refuse clearing in low-voltage session
// - Debugger bit low dedicates serial pins
// - Low-power brown-out enable active low
// - Trip select one picks low trip
// - Stack-fault reset enable resets on fault
// - 4 kW self-write protection ranges
// - 8 kW self-write protection ranges
// - Protected: external writes blocked, reads zero
// - Internal reads never blocked by protection
// - Four user ID words, read and write
// - ID word: part and revision identifiers
// - Stack flags set regardless of reset enable
//
// The APB slave port was decided locally.
`include "cwdp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cwdp_top #(
  parameter [8:0] PART_ID = 9'h0a5, // Arbitrary value
  parameter [4:0] REV_ID = 5'h01, // Arbitrary value
  parameter [0:0] FLASH_8KW = 1'b0 // Memory size variant
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Programmer port
  input wire prog_mode_active,
  input wire prog_lv_entry,
  input wire prog_wr,
  input wire prog_rd,
  input wire prog_bulk_erase,
  input wire [3:0] prog_addr,
  input wire [13:0] prog_wdata,
  output reg [13:0] prog_rdata,
  // External program memory access
  input wire ext_pm_rd,
  input wire ext_pm_wr,
  input wire [13:0] flash_rdata,
  output reg [13:0] ext_pm_rdata,
  output reg flash_ext_wr,
  // Internal self-write requests
  input wire self_wr_req,
  input wire [12:0] self_wr_addr,
  output reg flash_self_wr,
  output reg self_wr_refused,
  // Core status inputs
  input wire sleep_mode,
  input wire port_pullup_control,
  input wire stack_overflow_evt,
  input wire stack_underflow_evt,
  // Decoded settings
  output reg clock_output_pin_en,
  output reg brownout_active,
  output reg low_power_brownout_en,
  output reg brownout_low_trip,
  output reg code_protect_active,
  output reg reset_pin_is_reset,
  output reg reset_pin_pullup,
  output reg powerup_timer_en,
  output reg watchdog_active,
  output reg clock_source_external,
  output reg [1:0] clock_source_field,
  output reg clock_input_pin_io,
  output reg low_voltage_program_en,
  output reg debugger_pins_dedicated,
  output reg stack_fault_reset,
  output reg stack_overflow_flag,
  output reg stack_underflow_flag
);

  // Nonvolatile words
  reg [13:0] nv_cfg1_ff; // First configuration word
  reg [13:0] nv_cfg2_ff; // Second configuration word
  reg [13:0] uid_ff [0:3]; // User ID words
  // Latched copies used by the decode
  reg [13:0] lat_cfg1_ff;
  reg [13:0] lat_cfg2_ff;
  reg load_pend_ff; // Load still owed after reset
  reg prog_mode_d_ff; // Session level one cycle late
  // Software control bits
  reg [1:0] ctrl_ff;
  // APB decode
  wire setup_ph = psel & ~penable & ~pready; // Setup cycle
  wire acc_done = psel & penable & pready; // Completing access
  wire [15:0] idx = paddr[17:2];
  wire aligned = (paddr[1:0] == 2'h0);
  reg [31:0] rd_word;
  reg rd_hit;
  // Word image with unimplemented bits forced
  wire [13:0] cfg1_img = nv_cfg1_ff | `CWDP_C1_UNIMP;
  wire [13:0] cfg2_img = nv_cfg2_ff | `CWDP_C2_UNIMP;
  wire [13:0] part_revision_id_word = {PART_ID, REV_ID};
  // Protection decode from latched words
  wire cp_on = ~lat_cfg1_ff[`CWDP_C1_CP];
  wire [1:0] wrt = lat_cfg2_ff[`CWDP_C2_WRT+1:`CWDP_C2_WRT];
  wire [12:0] lim_small = FLASH_8KW ? `CWDP_LIM8_SMALL : `CWDP_LIM4_SMALL;
  wire [12:0] lim_half = FLASH_8KW ? `CWDP_LIM8_HALF : `CWDP_LIM4_HALF;
  wire [12:0] lim_all = FLASH_8KW ? `CWDP_LIM8_ALL : `CWDP_LIM4_ALL;
  reg wr_blocked;
  // Programmer word writes allowed only inside a session
  wire pgm_wr = prog_mode_active & prog_wr;
  wire pgm_erase = prog_mode_active & prog_bulk_erase;

  // APB read mux
  // Unaligned accesses answer like unmapped ones, but an unaligned write at the status index still clears the flags
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (idx)
      `CWDP_IDX_UID0: rd_word = {18'h00000, uid_ff[0]};
      `CWDP_IDX_UID1: rd_word = {18'h00000, uid_ff[1]};
      `CWDP_IDX_UID2: rd_word = {18'h00000, uid_ff[2]};
      `CWDP_IDX_UID3: rd_word = {18'h00000, uid_ff[3]};
      `CWDP_IDX_PART_REVISION_ID: rd_word = {18'h00000, part_revision_id_word};
      `CWDP_IDX_CFG1: rd_word = {18'h00000, cfg1_img};
      `CWDP_IDX_CFG2: rd_word = {18'h00000, cfg2_img};
      `CWDP_IDX_CTRL: rd_word = {30'h00000000, ctrl_ff};
      `CWDP_IDX_STAT: rd_word = {30'h00000000, stack_underflow_flag, stack_overflow_flag};
      default: rd_hit = 1'b0; // Unmapped
    endcase
    if (!aligned) begin
      rd_hit = 1'b0;
    end
  end

  // Self-write range check
  always @* begin
    case (wrt)
      `CWDP_EN_ON: wr_blocked = 1'b0;
      `CWDP_EN_RUN: wr_blocked = (self_wr_addr <= lim_small);
      `CWDP_EN_SW: wr_blocked = (self_wr_addr <= lim_half);
      default: wr_blocked = (self_wr_addr <= lim_all);
    endcase
  end

  // APB answer: ready one cycle after setup, no wait states
  // Read data and error are captured at setup and stand
  // for exactly the one access cycle, zero otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= (rd_hit & ~pwrite) ? rd_word : 32'h0000_0000;
        // Writes to read-only ID and unmapped words are errors
        pslverr <= ~rd_hit | (pwrite & ((idx == `CWDP_IDX_PART_REVISION_ID) |
                   (idx == `CWDP_IDX_CFG1) | (idx == `CWDP_IDX_CFG2)));
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Software control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 2'h0;
    end else if (acc_done & pwrite & ~pslverr & (idx == `CWDP_IDX_CTRL)) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // Configuration words: programmer writes and bulk erase
  // Erase outranks a word write landing in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_cfg1_ff <= `CWDP_BLANK;
      nv_cfg2_ff <= `CWDP_BLANK;
    end else if (pgm_erase) begin
      nv_cfg1_ff <= `CWDP_BLANK;
      nv_cfg2_ff <= `CWDP_BLANK;
    end else if (pgm_wr & (prog_addr == `CWDP_PSEL_CFG1)) begin
      nv_cfg1_ff <= prog_wdata | `CWDP_C1_UNIMP;
      // Protection once set stays set
      nv_cfg1_ff[`CWDP_C1_CP] <= prog_wdata[`CWDP_C1_CP] & nv_cfg1_ff[`CWDP_C1_CP];
    end else if (pgm_wr & (prog_addr == `CWDP_PSEL_CFG2)) begin
      nv_cfg2_ff <= prog_wdata | `CWDP_C2_UNIMP;
      if (prog_lv_entry) begin
        // Clearing refused while entered by low voltage
        nv_cfg2_ff[`CWDP_C2_LVP] <= nv_cfg2_ff[`CWDP_C2_LVP];
      end
    end
  end

  // User ID words, one per generate entry
  // Programmer port outranks the APB path in one cycle
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_uid
      wire apb_hit = acc_done & pwrite & ~pslverr & (idx == (`CWDP_IDX_UID0 + g));
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          uid_ff[g] <= `CWDP_BLANK;
        end else if (pgm_erase) begin
          uid_ff[g] <= `CWDP_BLANK;
        end else if (pgm_wr & (prog_addr == g)) begin
          uid_ff[g] <= prog_wdata;
        end else if (apb_hit) begin
          uid_ff[g] <= pwdata[13:0];
        end
      end
    end
  endgenerate

  // Programmer reads of ID and configuration words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rdata <= 14'h0000;
    end else if (prog_rd) begin
      case (prog_addr)
        4'h0: prog_rdata <= uid_ff[0];
        4'h1: prog_rdata <= uid_ff[1];
        4'h2: prog_rdata <= uid_ff[2];
        4'h3: prog_rdata <= uid_ff[3];
        `CWDP_PSEL_PART_REVISION_ID: prog_rdata <= part_revision_id_word;
        `CWDP_PSEL_CFG1: prog_rdata <= cfg1_img;
        `CWDP_PSEL_CFG2: prog_rdata <= cfg2_img;
        default: prog_rdata <= `CWDP_BLANK;
      endcase
    end
  end

  // Latch words after reset release and after each session ends
  // Decode never follows the live words, so a programming
  // session cannot disturb the running settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend_ff <= 1'b1;
      prog_mode_d_ff <= 1'b0;
      lat_cfg1_ff <= `CWDP_BLANK;
      lat_cfg2_ff <= `CWDP_BLANK;
    end else begin
      prog_mode_d_ff <= prog_mode_active;
      load_pend_ff <= prog_mode_d_ff & ~prog_mode_active;
      if (load_pend_ff) begin
        lat_cfg1_ff <= cfg1_img;
        lat_cfg2_ff <= cfg2_img;
      end
    end
  end

  // Decoded device settings
  // Registered once more so every setting output comes
  // straight from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_output_pin_en <= 1'b0;
      brownout_active <= 1'b0;
      low_power_brownout_en <= 1'b0;
      brownout_low_trip <= 1'b0;
      code_protect_active <= 1'b0;
      reset_pin_is_reset <= 1'b0;
      reset_pin_pullup <= 1'b0;
      powerup_timer_en <= 1'b0;
      watchdog_active <= 1'b0;
      clock_source_external <= 1'b0;
      clock_source_field <= 2'h0;
      clock_input_pin_io <= 1'b0;
      low_voltage_program_en <= 1'b0;
      debugger_pins_dedicated <= 1'b0;
    end else begin
      clock_output_pin_en <= ~lat_cfg1_ff[`CWDP_C1_CLOCK_OUTPUT_PIN];
      case (lat_cfg1_ff[`CWDP_C1_BOR+1:`CWDP_C1_BOR])
        `CWDP_EN_ON: brownout_active <= 1'b1;
        `CWDP_EN_RUN: brownout_active <= ~sleep_mode;
        `CWDP_EN_SW: brownout_active <= ctrl_ff[`CWDP_CTRL_SBOR];
        default: brownout_active <= 1'b0;
      endcase
      low_power_brownout_en <= ~lat_cfg2_ff[`CWDP_C2_LOW_POWER_BROWNOUT_ENABLE_N];
      brownout_low_trip <= lat_cfg2_ff[`CWDP_C2_BROWNOUT_TRIP_SELECT];
      code_protect_active <= cp_on;
      if (lat_cfg2_ff[`CWDP_C2_LVP]) begin
        // Select bit ignored; pin stays the reset input
        reset_pin_is_reset <= 1'b1;
        reset_pin_pullup <= 1'b1;
      end else if (lat_cfg1_ff[`CWDP_C1_EXTERNAL_RESET_PIN]) begin
        reset_pin_is_reset <= 1'b1;
        reset_pin_pullup <= 1'b1;
      end else begin
        reset_pin_is_reset <= 1'b0;
        reset_pin_pullup <= port_pullup_control;
      end
      // Driven from its own bit only, not from brown-out
      powerup_timer_en <= ~lat_cfg1_ff[`CWDP_C1_POWERUP_DELAY_TIMER];
      case (lat_cfg1_ff[`CWDP_C1_WDT+1:`CWDP_C1_WDT])
        `CWDP_EN_ON: watchdog_active <= 1'b1;
        `CWDP_EN_RUN: watchdog_active <= ~sleep_mode;
        `CWDP_EN_SW: watchdog_active <= ctrl_ff[`CWDP_CTRL_SWDT];
        default: watchdog_active <= 1'b0;
      endcase
      clock_source_field <= lat_cfg1_ff[`CWDP_C1_FOSC+1:`CWDP_C1_FOSC];
      clock_source_external <= (lat_cfg1_ff[`CWDP_C1_FOSC+1:`CWDP_C1_FOSC] != `CWDP_FOSC_INT);
      clock_input_pin_io <= (lat_cfg1_ff[`CWDP_C1_FOSC+1:`CWDP_C1_FOSC] == `CWDP_FOSC_INT);
      low_voltage_program_en <= lat_cfg2_ff[`CWDP_C2_LVP];
      debugger_pins_dedicated <= ~lat_cfg2_ff[`CWDP_C2_DBG];
    end
  end

  // External program memory gate; internal reads bypass this block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pm_rdata <= 14'h0000;
      flash_ext_wr <= 1'b0;
    end else begin
      // Gate follows the reported setting, so the pin-level
      // protection flag and the gate agree in every cycle
      if (ext_pm_rd) begin
        ext_pm_rdata <= code_protect_active ? 14'h0000 : flash_rdata;
      end
      flash_ext_wr <= ext_pm_wr & ~code_protect_active;
    end
  end

  // Self-writes limited by the range field only, not by protection
  // Refusal pulse lets the core see a blocked write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_self_wr <= 1'b0;
      self_wr_refused <= 1'b0;
    end else begin
      flash_self_wr <= self_wr_req & ~wr_blocked;
      self_wr_refused <= self_wr_req & wr_blocked;
    end
  end

  // Stack fault flags: set wins over a write-one clear
  // Fault reset follows the latched enable; flags do not
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_overflow_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
      stack_fault_reset <= 1'b0;
    end else begin
      if (stack_overflow_evt) begin
        stack_overflow_flag <= 1'b1;
      end else if (acc_done & pwrite & (idx == `CWDP_IDX_STAT) & pwdata[`CWDP_STAT_OVF]) begin
        stack_overflow_flag <= 1'b0;
      end
      if (stack_underflow_evt) begin
        stack_underflow_flag <= 1'b1;
      end else if (acc_done & pwrite & (idx == `CWDP_IDX_STAT) & pwdata[`CWDP_STAT_UNF]) begin
        stack_underflow_flag <= 1'b0;
      end
      stack_fault_reset <= (stack_overflow_evt | stack_underflow_evt) & lat_cfg2_ff[`CWDP_C2_STV];
    end
  end

endmodule
`default_nettype wire

// >>> test/cwdp_chk.sv
// Assertion checker for the configuration decode block
`include "cwdp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cwdp_chk #(
  parameter [8:0] PART_ID = 9'h0a5,
  parameter [4:0] REV_ID = 5'h01
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Programmer port
  input wire logic prog_mode_active,
  input wire logic prog_bulk_erase,
  input wire logic prog_rd,
  input wire logic [3:0] prog_addr,
  input wire logic [13:0] prog_rdata,
  // External access
  input wire logic ext_pm_rd,
  input wire logic ext_pm_wr,
  input wire logic [13:0] ext_pm_rdata,
  input wire logic flash_ext_wr,
  // Stack
  input wire logic stack_overflow_evt,
  input wire logic stack_underflow_evt,
  input wire logic stack_overflow_flag,
  input wire logic stack_underflow_flag,
  input wire logic stack_fault_reset,
  // Decoded settings
  input wire logic code_protect_active,
  input wire logic reset_pin_is_reset,
  input wire logic reset_pin_pullup,
  input wire logic clock_source_external,
  input wire logic [1:0] clock_source_field,
  input wire logic clock_input_pin_io,
  input wire logic low_voltage_program_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the session closed, and whether an erase was seen
  // while protection was reported active
  logic [2:0] quiet_ff;
  logic sess_ff;
  logic erased_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_ff <= 3'h0;
      sess_ff <= 1'b0;
      erased_ff <= 1'b0;
    end else begin
      sess_ff <= prog_mode_active;
      erased_ff <= code_protect_active & (erased_ff | (prog_bulk_erase & prog_mode_active));
      quiet_ff <= (prog_mode_active | sess_ff) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
    end
  end
  chk_prot_rd_zero: assert property (ext_pm_rd && code_protect_active |=> ext_pm_rdata == 14'h0000)
    else $error("protected external read returned data");
  chk_prot_wr_block: assert property (ext_pm_wr && code_protect_active |=> !flash_ext_wr)
    else $error("protected external write was granted");
  chk_ovf_flag: assert property (stack_overflow_evt |=> stack_overflow_flag)
    else $error("overflow flag not set");
  chk_unf_flag: assert property (stack_underflow_evt |=> stack_underflow_flag)
    else $error("underflow flag not set");
  chk_fault_cause: assert property (stack_fault_reset |-> $past(stack_overflow_evt) || $past(stack_underflow_evt))
    else $error("stack reset without a fault");
  chk_clk_source: assert property ($past(presetn, 2) |->
    clock_source_external == (clock_source_field != 2'h0) && clock_input_pin_io == (clock_source_field == 2'h0))
    else $error("clock source decode wrong");
  chk_lvp_pin: assert property (low_voltage_program_en |-> reset_pin_is_reset && reset_pin_pullup)
    else $error("reset pin not a reset input under low voltage programming");
  chk_hold_stable: assert property (quiet_ff >= 3'h5 |-> $stable(code_protect_active) &&
    $stable(clock_source_field) && $stable(low_voltage_program_en) && $stable(reset_pin_is_reset))
    else $error("decoded setting changed while running");
  chk_cp_erase: assert property ($fell(code_protect_active) |-> erased_ff)
    else $error("protection removed without erase");
  chk_unimp_ones: assert property (prog_rd && prog_addr == `CWDP_PSEL_CFG2 |=>
    (prog_rdata & `CWDP_C2_UNIMP) == `CWDP_C2_UNIMP)
    else $error("unimplemented bit read as zero");
  chk_part_id: assert property (prog_rd && prog_addr == `CWDP_PSEL_PART_REVISION_ID |=> prog_rdata == {PART_ID, REV_ID})
    else $error("id word wrong");
endmodule
`default_nettype wire

// >>> test/cwdp_prog_model.sv
// Programmer model driving the configuration programming port
`timescale 1ns/1ps
`default_nettype none
module cwdp_prog_model (
  // Clock
  input wire logic pclk,
  // Programming port
  output logic prog_mode_active,
  output logic prog_lv_entry,
  output logic prog_wr,
  output logic prog_rd,
  output logic prog_bulk_erase,
  output logic [3:0] prog_addr,
  output logic [13:0] prog_wdata,
  input wire logic [13:0] prog_rdata
);
  logic debug_session = 1'b0; // Set only for a debug session
  initial begin
    {prog_mode_active, prog_lv_entry, prog_wr, prog_rd, prog_bulk_erase} = 5'h00;
    prog_addr = 4'h0;
    prog_wdata = 14'h0;
  end
  // Open a session by low or high voltage entry
  task automatic open_sess(input logic lv);
    @(posedge pclk);
    prog_mode_active <= 1'b1;
    prog_lv_entry <= lv;
  endtask
  // Close and wait for the words to reload
  task automatic close_sess();
    @(posedge pclk);
    prog_mode_active <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // Protection is only lifted by a full erase or a reset
  task automatic erase();
    @(posedge pclk);
    prog_bulk_erase <= 1'b1;
    @(posedge pclk);
    prog_bulk_erase <= 1'b0;
  endtask
  // Write one word; debugger bit kept one outside debug
  task automatic put(input logic [3:0] a, input logic [13:0] d);
    @(posedge pclk);
    prog_wr <= 1'b1;
    prog_addr <= a;
    prog_wdata <= (a == 4'h8 && !debug_session) ? (d | 14'h1000) : d;
    @(posedge pclk);
    prog_wr <= 1'b0;
    prog_wdata <= ~prog_wdata;
  endtask
  // Read one word
  task automatic get(input logic [3:0] a, output logic [13:0] d);
    @(posedge pclk);
    prog_rd <= 1'b1;
    prog_addr <= a;
    @(posedge pclk);
    prog_rd <= 1'b0;
    @(posedge pclk);
    d = prog_rdata;
  endtask
endmodule
`default_nettype wire

// >>> test/cwdp_top_bench.sv
// Self-checking bench for the configuration decode block
`include "cwdp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cwdp_top_bench;
  localparam logic [8:0] PID = 9'h0a5; // Arbitrary value
  localparam logic [4:0] RID = 5'h01; // Arbitrary value
  // Design ports
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, prog_mode_active, prog_lv_entry, prog_wr, prog_rd, prog_bulk_erase;
  logic [3:0] prog_addr;
  logic [13:0] prog_wdata, prog_rdata, ext_pm_rdata, flash_rdata = 14'h0;
  logic ext_pm_rd = 1'b0, ext_pm_wr = 1'b0, flash_ext_wr, self_wr_req = 1'b0, flash_self_wr, self_wr_refused;
  logic [12:0] self_wr_addr = 13'h0;
  logic sleep_mode = 1'b0, port_pullup_control = 1'b0, stack_overflow_evt = 1'b0, stack_underflow_evt = 1'b0;
  logic clock_output_pin_en, brownout_active, low_power_brownout_en, brownout_low_trip, code_protect_active;
  logic reset_pin_is_reset, reset_pin_pullup, powerup_timer_en, watchdog_active, clock_source_external;
  logic [1:0] clock_source_field;
  logic clock_input_pin_io, low_voltage_program_en, debugger_pins_dedicated;
  logic stack_fault_reset, stack_overflow_flag, stack_underflow_flag;
  // Bench state
  int n_fail = 0, samples_checked = 0;
  logic [15:0] lfsr = 16'h002d;
  logic [31:0] rd;
  logic er, sbor = 1'b0, swdt = 1'b0;
  logic [13:0] w1 = 14'h3fff, w2 = 14'h3fff, pd;
  logic [12:0] lim;
  wire logic [14:0] seen = {clock_output_pin_en, brownout_active, low_power_brownout_en, brownout_low_trip,
    code_protect_active, reset_pin_is_reset, reset_pin_pullup, powerup_timer_en, watchdog_active,
    clock_source_external, clock_source_field, clock_input_pin_io, low_voltage_program_en, debugger_pins_dedicated};
  cwdp_top #(.PART_ID(PID), .REV_ID(RID)) u_cwdp_top (.*);
  cwdp_prog_model u_cwdp_prog_model (.*);
  // Clock at 250 MHz
  initial begin
    forever #2 pclk = ~pclk;
  end
  // Pseudo-random source
  function automatic logic [13:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[13:0];
  endfunction
  // Two-bit enable field model
  function automatic logic en2(input logic [1:0] f, input logic s, input logic sw);
    return f == 2'h3 || (f == 2'h2 && !s) || (f == 2'h1 && sw);
  endfunction
  // Expected decoded settings
  function automatic logic [14:0] dec(input logic [13:0] c1, input logic [13:0] c2);
    logic low_voltage_program_enable;
    low_voltage_program_enable = c2[13];
    return {!c1[11], en2(c1[10:9], sleep_mode, sbor), !c2[11], c2[10], !c1[7], low_voltage_program_enable | c1[6],
      low_voltage_program_enable | c1[6] | port_pullup_control, !c1[5], en2(c1[4:3], sleep_mode, swdt), c1[1:0] != 2'h0,
      c1[1:0], c1[1:0] == 2'h0, low_voltage_program_enable, !c2[12]};
  endfunction
  // Byte address of a register index
  function automatic logic [17:0] ad(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One APB transfer, bounded wait for ready
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Look between edges, where pready and data are settled
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      n_fail++;
      summarize();
    end
    // Release only after the edge that samples pready high
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk("blank decode", {17'h0, dec(w1, w2)}, {17'h0, seen});
    for (int i = 0; i < 4; i++) begin
      pd = rnd();
      apb(1'b1, ad(`CWDP_IDX_UID0 + 16'(i)), {18'h0, pd});
      apb(1'b0, ad(`CWDP_IDX_UID0 + 16'(i)), 32'h0);
      chk("user id", {18'h0, pd}, rd);
    end
    apb(1'b0, ad(`CWDP_IDX_PART_REVISION_ID), 32'h0);
    chk("id word", {18'h0, PID, RID}, rd);
    apb(1'b0, 18'h3fffc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("id test done");
    for (int k = 0; k < 8; k++) begin
      u_cwdp_prog_model.open_sess(k[2]);
      u_cwdp_prog_model.erase();
      u_cwdp_prog_model.debug_session = k[0];
      w1 = rnd() | `CWDP_C1_UNIMP;
      w2 = rnd() | `CWDP_C2_UNIMP;
      {w1[10:9], w1[4:3], w1[1:0], w2[1:0]} = {k[1:0], ~k[1:0], k[1:0], k[1:0]};
      u_cwdp_prog_model.put(`CWDP_PSEL_CFG1, w1);
      u_cwdp_prog_model.put(`CWDP_PSEL_CFG1, w1 | 14'h0080);
      u_cwdp_prog_model.put(`CWDP_PSEL_CFG2, w2);
      w2[13] = w2[13] | k[2];
      w2[12] = w2[12] | !k[0];
      u_cwdp_prog_model.get(`CWDP_PSEL_CFG1, pd);
      chk("cfg1", {18'h0, w1}, {18'h0, pd});
      u_cwdp_prog_model.get(`CWDP_PSEL_CFG2, pd);
      chk("cfg2", {18'h0, w2}, {18'h0, pd});
      u_cwdp_prog_model.close_sess();
      pd = rnd();
      {sleep_mode, port_pullup_control} <= pd[1:0];
      {swdt, sbor} = pd[3:2];
      apb(1'b1, ad(`CWDP_IDX_CTRL), {30'h0, pd[3:2]});
      repeat (3) @(posedge pclk);
      #1 chk("decode", {17'h0, dec(w1, w2)}, {17'h0, seen});
      apb(1'b0, ad(`CWDP_IDX_CFG1), 32'h0);
      chk("cfg1 read", {18'h0, w1}, rd);
      lim = w2[1:0] == 2'h2 ? 13'h01ff : w2[1:0] == 2'h1 ? 13'h07ff : 13'h0fff;
      for (int j = 0; j < 3; j++) begin
        pd = rnd();
        @(posedge pclk);
        self_wr_req <= 1'b1;
        self_wr_addr <= j == 0 ? lim : j == 1 ? {1'b0, 12'(lim + 13'h1)} : {1'b0, pd[11:0]};
        @(posedge pclk);
        self_wr_req <= 1'b0;
        #1 chk("self write", {30'h0, w2[1:0] == 2'h3 || self_wr_addr > lim, w2[1:0] != 2'h3 && self_wr_addr <= lim},
          {30'h0, flash_self_wr, self_wr_refused});
      end
      @(posedge pclk);
      {flash_rdata, ext_pm_rd} <= {pd, 1'b1};
      @(posedge pclk);
      {flash_rdata, ext_pm_rd} <= {~pd, 1'b0};
      #1 chk("ext read", {18'h0, w1[7] ? pd : 14'h0}, {18'h0, ext_pm_rdata});
      @(posedge pclk);
      ext_pm_wr <= 1'b1;
      @(posedge pclk);
      ext_pm_wr <= 1'b0;
      #1 chk("ext write", {31'h0, w1[7]}, {31'h0, flash_ext_wr});
      @(posedge pclk);
      {stack_overflow_evt, stack_underflow_evt} <= {k[0], !k[0]};
      @(posedge pclk);
      {stack_overflow_evt, stack_underflow_evt} <= 2'b00;
      #1 chk("stack", {29'h0, w2[9], k[0], !k[0]},
        {29'h0, stack_fault_reset, stack_overflow_flag, stack_underflow_flag});
      apb(1'b1, ad(`CWDP_IDX_STAT), 32'h3);
      apb(1'b0, ad(`CWDP_IDX_STAT), 32'h0);
      chk("status clear", 32'h0, rd);
      $display("config pass %0d done", k);
    end
    summarize();
  end
endmodule
bind cwdp_top cwdp_chk #(.PART_ID(PART_ID), .REV_ID(REV_ID)) u_cwdp_chk (.*);
`default_nettype wire
